// >>> verilog/dtms_defs.vh
/*
 * Constants for the direct transfer and module standby block:
 * register offsets, field positions, reset values and state counts.
 * Assumes inclusion by bare name from the design file.
 */
`ifndef DTMS_DEFS_VH
`define DTMS_DEFS_VH

// Register offsets on the plain register port.
`define DTMS_ADDR_STOP_1 4'h0
`define DTMS_ADDR_STOP_2 4'h1
`define DTMS_ADDR_SYS_ONE 4'h2
`define DTMS_ADDR_SYS_TWO 4'h3
`define DTMS_ADDR_TIMER_A 4'h4
`define DTMS_ADDR_STATUS 4'h5

// Reset values.
`define DTMS_STOP_RESET 8'hff

// Clock-stop register 1 fields.
`define DTMS_B_TIMER_A 0
`define DTMS_B_TIMER_C 1
`define DTMS_B_TIMER_F 2
`define DTMS_B_TIMER_G 3
`define DTMS_B_ADC 4
`define DTMS_B_SERIAL_TWO 5
`define DTMS_B_SERIAL_ONE 6

// Clock-stop register 2 fields.
`define DTMS_B_LCD 0
`define DTMS_B_PWM 1
`define DTMS_B_WATCHDOG 2
`define DTMS_B_EVENT 3

// System control one fields.
`define DTMS_B_STANDBY_SELECT 7
`define DTMS_B_WAIT_HI 6
`define DTMS_B_WAIT_LO 4
`define DTMS_B_LOW_SPEED_ON 3

// System control two fields.
`define DTMS_B_DIRECT_ENABLE 3
`define DTMS_B_MEDIUM_SELECT 2

// Timer A mode register field.
`define DTMS_B_TIMER_A_BIT3 3

// Operating modes.
`define DTMS_MODE_HIGH 2'h0
`define DTMS_MODE_MEDIUM 2'h1
`define DTMS_MODE_SUB 2'h2

// State counts of a direct transition.
`define DTMS_SLEEP_STATES 2
`define DTMS_INTERNAL_STATES 1
`define DTMS_EXCEPTION_STATES 14

// Standby wait states for each wait-select code; codes 4 to 7 share the last.
`define DTMS_WAIT_0 8192
`define DTMS_WAIT_1 16384
`define DTMS_WAIT_2 2048
`define DTMS_WAIT_3 4096
`define DTMS_WAIT_OTHER 256

`endif

// >>> verilog/dtms_core.v
/*
 * Direct transfer between operating speed modes on SLEEP, and per-module
 * standby through two clock-stop registers.
 * Assumes the CPU pulses SLEEP_EXEC for one cycle, and that one-cycle
 * enables PHI_ENABLE / SUB_ENABLE mark one state of the system clock and
 * subclock (state timing is counted on these enables, not derived here).
 * All inputs come from logic on CLK, so none of them is synchronised here.
 * Entry into subactive from watch belongs to wake-up logic outside this
 * block; that logic reports the entry by writing the subactive code to the
 * status offset while the sequencer is idle, not while it is parked.
 * Peripherals gate their own clocks with CLOCK_RUN_1 and CLOCK_RUN_2.
 */
`timescale 1ns/1ps
`include "dtms_defs.vh"

module dtms_core #(
	parameter WAIT_W = 14
) (
	input wire CLK,
	input wire RESET,
	input wire [3:0] ADDR,
	input wire [7:0] WDATA,
	input wire WR,
	input wire RD,
	output reg [7:0] RDATA,
	input wire SLEEP_EXEC,
	input wire DT_IRQ_ENABLE,
	input wire PHI_ENABLE,
	input wire SUB_ENABLE,
	output reg [1:0] MODE,
	output reg TRANSIT,
	output reg EXCEPTION_START,
	output reg SLEEP_WATCH,
	output reg [6:0] CLOCK_RUN_1,
	output reg [3:0] CLOCK_RUN_2
);

////////////////////////////////////////////////////////////////////////////////
// Sequencer states.
localparam ST_IDLE = 3'h0;
localparam ST_SLEEP = 3'h1;
localparam ST_WAIT = 3'h2;
localparam ST_EXC = 3'h3;
localparam ST_HALT = 3'h4;

// Counter loads, held 32 bits wide and cut to the counter width where used.
localparam [31:0] SLEEP_LOAD = `DTMS_SLEEP_STATES + `DTMS_INTERNAL_STATES - 1;
localparam [31:0] EXC_LOAD = `DTMS_EXCEPTION_STATES - 1;
localparam [31:0] WAIT_LOAD_0 = `DTMS_WAIT_0 - 1;
localparam [31:0] WAIT_LOAD_1 = `DTMS_WAIT_1 - 1;
localparam [31:0] WAIT_LOAD_2 = `DTMS_WAIT_2 - 1;
localparam [31:0] WAIT_LOAD_3 = `DTMS_WAIT_3 - 1;
localparam [31:0] WAIT_LOAD_OTHER = `DTMS_WAIT_OTHER - 1;

// Software-visible registers.
reg [7:0] module_clock_stop_1;
reg [7:0] module_clock_stop_2;
reg [7:0] system_control_one;
reg [7:0] system_control_two;
reg [7:0] timer_a_mode_register;
// Sequencer state, its counter and the mode it is heading for.
reg [2:0] state;
reg [WAIT_W-1:0] count;
reg [1:0] target;
// Combinational results of the decode and the read mux.
reg [7:0] next_rdata;
reg [WAIT_W-1:0] wait_len;
reg go_direct;
reg [1:0] next_target;

// Control fields as named bits.
wire standby_select = system_control_one[`DTMS_B_STANDBY_SELECT];
wire low_speed_on = system_control_one[`DTMS_B_LOW_SPEED_ON];
wire [2:0] standby_wait_select = system_control_one[`DTMS_B_WAIT_HI:`DTMS_B_WAIT_LO];
wire direct_transfer_enable = system_control_two[`DTMS_B_DIRECT_ENABLE];
wire medium_speed_select = system_control_two[`DTMS_B_MEDIUM_SELECT];
wire timer_a_clock_bit_three = timer_a_mode_register[`DTMS_B_TIMER_A_BIT3];

// Wait states chosen by the wait-select field, as a load for a count to zero.
// A WAIT_W below 14 would cut the longest wait, so keep the default.
function [WAIT_W-1:0] wait_states;
	input [2:0] sel;
	begin
		case (sel)
			3'h0: wait_states = WAIT_LOAD_0[WAIT_W-1:0];
			3'h1: wait_states = WAIT_LOAD_1[WAIT_W-1:0];
			3'h2: wait_states = WAIT_LOAD_2[WAIT_W-1:0];
			3'h3: wait_states = WAIT_LOAD_3[WAIT_W-1:0];
			default: wait_states = WAIT_LOAD_OTHER[WAIT_W-1:0];
		endcase
	end
endfunction

////////////////////////////////////////////////////////////////////////////////
// Direct transfer decode, evaluated when SLEEP executes.
// Decoded every cycle; the sequencer looks at go_direct and next_target only in idle, so a SLEEP
// during a running transfer is ignored; wait_len is read when the sleep states end.
always @* begin
	go_direct = 1'b0;
	next_target = MODE;
	wait_len = wait_states(standby_wait_select);
	if (direct_transfer_enable) begin
		if (MODE == `DTMS_MODE_MEDIUM && !standby_select && !low_speed_on &&
				!medium_speed_select) begin
			go_direct = 1'b1;
			next_target = `DTMS_MODE_HIGH;
		end
		// subactive to high; subactive to medium.
		// Medium-select only picks the target; it is not part of the entry test.
		if (MODE == `DTMS_MODE_SUB && standby_select && !low_speed_on &&
				timer_a_clock_bit_three) begin
			go_direct = 1'b1;
			next_target = medium_speed_select ? `DTMS_MODE_MEDIUM : `DTMS_MODE_HIGH;
		end
	end
end

////////////////////////////////////////////////////////////////////////////////
// Transition sequencer: old-clock states, optional wait, new-clock exception.
always @(posedge CLK) begin
	if (RESET) begin
		// Reset leaves medium speed with no transfer running.
		state <= ST_IDLE;
		count <= {WAIT_W{1'b0}};
		target <= `DTMS_MODE_MEDIUM;
		MODE <= `DTMS_MODE_MEDIUM;
		TRANSIT <= 1'b0;
		EXCEPTION_START <= 1'b0;
		SLEEP_WATCH <= 1'b0;
	end else begin
		EXCEPTION_START <= 1'b0;
		case (state)
			ST_IDLE: begin
				if (SLEEP_EXEC && go_direct) begin
					// two SLEEP states plus one internal state.
					state <= ST_SLEEP;
					count <= SLEEP_LOAD[WAIT_W-1:0];
					target <= next_target;
					TRANSIT <= 1'b1;
				end else if (WR && ADDR == `DTMS_ADDR_STATUS &&
						WDATA[1:0] == `DTMS_MODE_SUB) begin
					// Wake-up logic outside reports entry into subactive; only
					// accepted in idle so a running transfer keeps its mode.
					MODE <= `DTMS_MODE_SUB;
				end
			end
			ST_SLEEP: begin
				// counted in the clock before the transition.
				if (MODE == `DTMS_MODE_SUB ? SUB_ENABLE : PHI_ENABLE) begin
					if (count == {WAIT_W{1'b0}}) begin
						MODE <= target;
						if (MODE == `DTMS_MODE_SUB) begin
							state <= ST_WAIT;
							count <= wait_len;
						end else begin
							state <= ST_EXC;
							count <= EXC_LOAD[WAIT_W-1:0];
							EXCEPTION_START <= DT_IRQ_ENABLE;
						end
					end else begin
						count <= count - 1'b1;
					end
				end
			end
			ST_WAIT: begin
				// Wait states are counted in the new system clock.
				if (PHI_ENABLE) begin
					if (count == {WAIT_W{1'b0}}) begin
						state <= ST_EXC;
						count <= EXC_LOAD[WAIT_W-1:0];
						EXCEPTION_START <= DT_IRQ_ENABLE;
					end else begin
						count <= count - 1'b1;
					end
				end
			end
			ST_EXC: begin
				// The enable is looked at only in the first exception state; a later
				// change does not stop handling already begun.
				if (!DT_IRQ_ENABLE && count == EXC_LOAD[WAIT_W-1:0]) begin
					// disabled interrupt parks in sleep or watch.
					state <= ST_HALT;
					TRANSIT <= 1'b0;
					SLEEP_WATCH <= 1'b1;
				end else if (PHI_ENABLE) begin
					// fourteen exception states in the new clock.
					if (count == {WAIT_W{1'b0}}) begin
						state <= ST_IDLE;
						TRANSIT <= 1'b0;
					end else begin
						count <= count - 1'b1;
					end
				end
			end
			ST_HALT: begin
				// Left only by a reset; wake-up sources are outside this block.
				SLEEP_WATCH <= 1'b1;
			end
			default: state <= ST_IDLE;
		endcase
	end
end

////////////////////////////////////////////////////////////////////////////////
// Register writes.
// Writes land at the edge that samples WR; CLOCK_RUN follows one edge later.
always @(posedge CLK) begin
	if (RESET) begin
		module_clock_stop_1 <= `DTMS_STOP_RESET;
		module_clock_stop_2 <= `DTMS_STOP_RESET;
		system_control_one <= 8'h00;
		system_control_two <= 8'h00;
		timer_a_mode_register <= 8'h00;
	end else if (WR) begin
		case (ADDR)
			// a 0 stops; a 1 restores.
			`DTMS_ADDR_STOP_1: module_clock_stop_1 <= WDATA;
			`DTMS_ADDR_STOP_2: module_clock_stop_2 <= WDATA;
			`DTMS_ADDR_SYS_ONE: system_control_one <= WDATA;
			`DTMS_ADDR_SYS_TWO: system_control_two <= WDATA;
			`DTMS_ADDR_TIMER_A: timer_a_mode_register <= WDATA;
			// The status offset holds no register; a subactive report there is
			// taken by the sequencer instead.
			default: ;
		endcase
	end
end

////////////////////////////////////////////////////////////////////////////////
// Read mux; unmapped offsets read zero.
// The status byte lets software poll a transfer instead of waiting for
// the exception.
always @* begin
	case (ADDR)
		`DTMS_ADDR_STOP_1: next_rdata = module_clock_stop_1;
		`DTMS_ADDR_STOP_2: next_rdata = module_clock_stop_2;
		`DTMS_ADDR_SYS_ONE: next_rdata = system_control_one;
		`DTMS_ADDR_SYS_TWO: next_rdata = system_control_two;
		`DTMS_ADDR_TIMER_A: next_rdata = timer_a_mode_register;
		`DTMS_ADDR_STATUS: next_rdata = {3'h0, SLEEP_WATCH, TRANSIT, state == ST_WAIT, MODE};
		default: next_rdata = 8'h00;
	endcase
end

// Read data stands only in the cycle after the strobe.
// Forcing zero outside the read cycle keeps stale data off the bus.
always @(posedge CLK) begin
	if (RESET) begin
		RDATA <= 8'h00;
	end else begin
		RDATA <= RD ? next_rdata : 8'h00;
	end
end

////////////////////////////////////////////////////////////////////////////////
// Clock-run enables to each module; peripherals AND these with the clock
// in their own glitch-free gate cells, so no gating happens in logic here.
// Bit 7 of the first register and bits 7:4 of the second gate nothing; they
// read back as written.
always @(posedge CLK) begin
	if (RESET) begin
		CLOCK_RUN_1 <= 7'h7f;
		CLOCK_RUN_2 <= 4'hf;
	end else begin
		// a cleared bit halts that module's clock.
		CLOCK_RUN_1[0] <= module_clock_stop_1[`DTMS_B_TIMER_A];
		CLOCK_RUN_1[1] <= module_clock_stop_1[`DTMS_B_TIMER_C];
		CLOCK_RUN_1[2] <= module_clock_stop_1[`DTMS_B_TIMER_F];
		CLOCK_RUN_1[3] <= module_clock_stop_1[`DTMS_B_TIMER_G];
		CLOCK_RUN_1[4] <= module_clock_stop_1[`DTMS_B_ADC];
		CLOCK_RUN_1[5] <= module_clock_stop_1[`DTMS_B_SERIAL_TWO];
		CLOCK_RUN_1[6] <= module_clock_stop_1[`DTMS_B_SERIAL_ONE];
		CLOCK_RUN_2[0] <= module_clock_stop_2[`DTMS_B_LCD];
		CLOCK_RUN_2[1] <= module_clock_stop_2[`DTMS_B_PWM];
		CLOCK_RUN_2[2] <= module_clock_stop_2[`DTMS_B_WATCHDOG];
		CLOCK_RUN_2[3] <= module_clock_stop_2[`DTMS_B_EVENT];
	end
end

endmodule // dtms_core

// >>> testbench/dtms_core_checker.sv
/* Assertion checker for dtms_core, seeing only its ports.
   Assumes the bind below reaches every dtms_core instance. */
`timescale 1ns/1ps
module dtms_core_checker #(
	parameter WAIT_W = 14
) (
	input wire CLK,
	input wire RESET,
	input wire [3:0] ADDR,
	input wire [7:0] WDATA,
	input wire WR,
	input wire RD,
	input wire [7:0] RDATA,
	input wire SLEEP_EXEC,
	input wire DT_IRQ_ENABLE,
	input wire PHI_ENABLE,
	input wire [1:0] MODE,
	input wire TRANSIT,
	input wire EXCEPTION_START,
	input wire SLEEP_WATCH,
	input wire [6:0] CLOCK_RUN_1,
	input wire [3:0] CLOCK_RUN_2
);
	reg [4:0] exc_cnt;
	default clocking @(posedge CLK); endclocking
	default disable iff (RESET);
////////////////////////////////////////////////////////////////////////////////
	// Counts system clock states since exception handling began; saturates.
	always @(posedge CLK) begin
		if (RESET || EXCEPTION_START)
			exc_cnt <= 5'h00;
		else if (PHI_ENABLE && exc_cnt != 5'h1f)
			exc_cnt <= exc_cnt + 5'h01;
	end
////////////////////////////////////////////////////////////////////////////////
	a_reset_gates: assert property (disable iff (1'b0)
		RESET ##1 RESET |=> CLOCK_RUN_1 == 7'h7f && CLOCK_RUN_2 == 4'hf)
		else $error("gates not open after reset");
	a_rdata_idle: assert property (!RD |=> RDATA == 8'h00)
		else $error("read data without a read");
	a_exc_single: assert property (EXCEPTION_START |=> !EXCEPTION_START)
		else $error("exception start longer than one cycle");
	a_exc_enabled: assert property (EXCEPTION_START |-> DT_IRQ_ENABLE && TRANSIT)
		else $error("exception start while disabled or idle");
	a_mode_moves: assert property (!$past(RESET) && $changed(MODE) |->
		TRANSIT || (MODE == 2'h2 && $past(WR && ADDR == 4'h5)))
		else $error("mode changed outside a transfer");
	a_transit_cause: assert property ($rose(TRANSIT) |-> $past(SLEEP_EXEC))
		else $error("transfer began without sleep");
	a_gate_one: assert property (
		WR && ADDR == 4'h0 ##1 !(WR && ADDR == 4'h0) |=> CLOCK_RUN_1 == $past(WDATA[6:0], 2))
		else $error("first gate set does not follow write");
	a_gate_two: assert property (
		WR && ADDR == 4'h1 ##1 !(WR && ADDR == 4'h1) |=> CLOCK_RUN_2 == $past(WDATA[3:0], 2))
		else $error("second gate set does not follow write");
	a_watch_hold: assert property (SLEEP_WATCH |=> SLEEP_WATCH)
		else $error("parked state left without reset");
	a_exc_count: assert property (
		!$past(RESET) && $fell(TRANSIT) && !SLEEP_WATCH |-> exc_cnt >= 5'h0d && exc_cnt <= 5'h0f)
		else $error("exception handling length wrong");
	c_exception: cover property (EXCEPTION_START);
	c_parked: cover property ($rose(SLEEP_WATCH));
	c_gate_write: cover property (WR && ADDR == 4'h1);
	c_sub_leave: cover property ($past(MODE) == 2'h2 && MODE != 2'h2);
endmodule // dtms_core_checker

bind dtms_core dtms_core_checker #(.WAIT_W(WAIT_W)) chk (.CLK(CLK), .RESET(RESET),
	.ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .SLEEP_EXEC(SLEEP_EXEC),
	.DT_IRQ_ENABLE(DT_IRQ_ENABLE), .PHI_ENABLE(PHI_ENABLE), .MODE(MODE), .TRANSIT(TRANSIT),
	.EXCEPTION_START(EXCEPTION_START), .SLEEP_WATCH(SLEEP_WATCH),
	.CLOCK_RUN_1(CLOCK_RUN_1), .CLOCK_RUN_2(CLOCK_RUN_2));

// >>> testbench/dtms_cpu_model.sv
/* State-enable source standing in for the CPU clock generator.
   Assumes one clock; slow stretches system states to one in four. */
`timescale 1ns/1ps
module dtms_cpu_model (
	input wire clk,
	input wire reset,
	input wire slow,
	output reg phi_en,
	output reg sub_en
);
	reg [1:0] div;
	// Subclock states come one in four: slower than the full-rate system clock and as slow as the slowed one, at another phase.
	always @(posedge clk) begin
		if (reset) begin
			div <= 2'h0;
			phi_en <= 1'b0;
			sub_en <= 1'b0;
		end else begin
			div <= div + 2'h1;
			phi_en <= !slow || div == 2'h3;
			sub_en <= div == 2'h1;
		end
	end
endmodule // dtms_cpu_model

// >>> testbench/dtms_core_test.sv
/* Self-checking bench for dtms_core with the state-enable model.
   Assumes the checker is bound from its own file. */
`timescale 1ns/1ps
`define CHK(n, e, a) begin cmp_count++; if ((a) !== (e)) begin failures++; \
	$display("[FAIL] %s exp %h got %h", n, e, a); end end
module dtms_core_test;
	reg CLK = 1'b0, RESET = 1'b1, WR = 1'b0, RD = 1'b0, SLEEP_EXEC = 1'b0;
	reg DT_IRQ_ENABLE = 1'b1, slow = 1'b0, rd_d = 1'b0;
	reg [3:0] ADDR = 4'h0;
	reg [7:0] WDATA = 8'h00, er;
	reg [15:0] seed = 16'h3b8b; // Fixed start of the random sequence.
	reg [1:0] em, prev_mode = 2'h1;
	wire PHI_ENABLE, SUB_ENABLE, TRANSIT, EXCEPTION_START, SLEEP_WATCH;
	wire [7:0] RDATA;
	wire [1:0] MODE;
	wire [6:0] CLOCK_RUN_1;
	wire [3:0] CLOCK_RUN_2;
	integer failures = 0, cmp_count = 0, cycles = 0, i, k, wait_cnt = 0, ew;
	reg [7:0] rdq[$];
	reg [1:0] modeq[$];
	integer waitq[$];
	dtms_core dut (.CLK(CLK), .RESET(RESET), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
		.RDATA(RDATA), .SLEEP_EXEC(SLEEP_EXEC), .DT_IRQ_ENABLE(DT_IRQ_ENABLE),
		.PHI_ENABLE(PHI_ENABLE), .SUB_ENABLE(SUB_ENABLE), .MODE(MODE), .TRANSIT(TRANSIT),
		.EXCEPTION_START(EXCEPTION_START), .SLEEP_WATCH(SLEEP_WATCH),
		.CLOCK_RUN_1(CLOCK_RUN_1), .CLOCK_RUN_2(CLOCK_RUN_2));
	dtms_cpu_model cpu (.clk(CLK), .reset(RESET), .slow(slow), .phi_en(PHI_ENABLE),
		.sub_en(SUB_ENABLE));
	always #5 CLK = ~CLK;
////////////////////////////////////////////////////////////////////////////////
	function [15:0] lfsr(input [15:0] s);
		lfsr = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	task summarize;
		begin
			$display("comparisons %0d mismatches %0d", cmp_count, failures);
			if (failures == 0 && cmp_count > 0)
				$display("Regression OK");
			else
				$display("Regression broken");
			$finish;
		end
	endtask
	// An idle cycle follows each strobe so no strobe is driven twice at one edge.
	task wr(input [3:0] a, input [7:0] d);
		begin
			ADDR <= a; WDATA <= d; WR <= 1'b1; @(posedge CLK);
			WR <= 1'b0; @(posedge CLK);
		end
	endtask
	task rd(input [3:0] a, input [7:0] e);
		begin
			rdq.push_back(e); ADDR <= a; RD <= 1'b1; @(posedge CLK);
			RD <= 1'b0; @(posedge CLK);
		end
	endtask
	task sleep_pulse;
		begin
			SLEEP_EXEC <= 1'b1; @(posedge CLK);
			SLEEP_EXEC <= 1'b0; @(negedge CLK);
		end
	endtask
	// A second sleep mid-transfer must not start another exception.
	// The expected wait w counts clock cycles between mode change and exception.
	task transfer(input [1:0] m, input irq, input integer w);
		begin
			DT_IRQ_ENABLE <= irq;
			if (irq) begin
				modeq.push_back(m);
				waitq.push_back(w);
			end
			@(posedge CLK); sleep_pulse;
			`CHK("transit", 1'b1, TRANSIT)
			@(posedge CLK); sleep_pulse;
			for (k = 0; k < 9000 && TRANSIT === 1'b1; k++) @(negedge CLK);
			@(negedge CLK);
			`CHK("mode", m, MODE)
			`CHK("parked", !irq, SLEEP_WATCH)
			@(posedge CLK);
		end
	endtask
////////////////////////////////////////////////////////////////////////////////
	// Read data and exception modes are compared where they stand.
	always @(posedge CLK) rd_d <= RD;
	always @(negedge CLK) begin
		if (rd_d && rdq.size() > 0) begin
			er = rdq.pop_front(); `CHK("read", er, RDATA)
		end
		// Cycles since the last mode change, the wait before exception handling.
		if (MODE !== prev_mode)
			wait_cnt = 0;
		else
			wait_cnt++;
		prev_mode = MODE;
		if (EXCEPTION_START === 1'b1) begin
			em = modeq.size() > 0 ? modeq.pop_front() : 2'h3; `CHK("exc mode", em, MODE)
			ew = waitq.size() > 0 ? waitq.pop_front() : -1;
			`CHK("exc wait", ew, wait_cnt)
		end
	end
	// Cuts a hang short; the whole run needs well under this.
	always @(posedge CLK) begin
		cycles++;
		if (cycles == 12000) begin failures++; summarize; end
	end
	initial begin
		repeat (5) @(posedge CLK);
		RESET <= 1'b0; @(posedge CLK);
		rd(4'h0, 8'hff); rd(4'h1, 8'hff);
		for (i = 0; i < 7; i++) begin
			wr(4'h0, ~(8'h01 << i)); @(negedge CLK);
			`CHK("run one", ~(7'h01 << i), CLOCK_RUN_1)
			@(posedge CLK);
		end
		for (i = 0; i < 4; i++) begin
			wr(4'h1, ~(8'h01 << i)); @(negedge CLK);
			`CHK("run two", ~(4'h1 << i), CLOCK_RUN_2)
			@(posedge CLK);
		end
		for (i = 0; i < 4; i++) begin
			seed = lfsr(seed); wr(4'h0, seed[7:0]); wr(4'h1, seed[15:8]);
			rd(4'h0, seed[7:0]); rd(4'h1, seed[15:8]); @(negedge CLK);
			`CHK("run mix", {seed[11:8], seed[6:0]}, {CLOCK_RUN_2, CLOCK_RUN_1})
			@(posedge CLK);
		end
		wr(4'h0, 8'hff); wr(4'h1, 8'hff); wr(4'he, 8'h00);
		rd(4'hf, 8'h00); rd(4'h0, 8'hff); rd(4'h1, 8'hff);
		for (i = 0; i < 3; i++) begin
			wr(4'h2, i == 1 ? 8'h08 : 8'h00); wr(4'h3, i == 2 ? 8'h0c : 8'h08 * (i & 1));
			sleep_pulse; repeat (3) @(negedge CLK);
			`CHK("no transit", 1'b0, TRANSIT)
			@(posedge CLK);
		end
		wr(4'h2, 8'h00); wr(4'h3, 8'h08); slow <= 1'b1;
		transfer(2'h0, 1'b1, 0);
		slow <= 1'b0;
		wr(4'h5, 8'h02);
		rd(4'h5, 8'h02);
		wr(4'h2, 8'h80);
		wr(4'h3, 8'h08);
		sleep_pulse;
		repeat (3) @(negedge CLK);
		`CHK("no sub transit", 1'b0, TRANSIT)
		@(posedge CLK);
		wr(4'h4, 8'h08);
		transfer(2'h0, 1'b1, 8192);
		wr(4'h5, 8'h02);
		wr(4'h2, 8'hc0);
		wr(4'h3, 8'h0c);
		transfer(2'h1, 1'b1, 256);
		RESET <= 1'b1; slow <= 1'b0; repeat (5) @(posedge CLK);
		RESET <= 1'b0; @(posedge CLK);
		wr(4'h3, 8'h08); transfer(2'h0, 1'b0, 0);
		summarize;
	end
endmodule // dtms_core_test
